// [src/adc_link_map.svh]
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

// ==========================================================================
// Control byte layout
`define CTRL_CH_MSB           6
`define CTRL_CH_LSB           4
`define CTRL_MODE_BIT         2
`define CTRL_PD_MSB           1
`define CTRL_PD_LSB           0

// ==========================================================================
// Frame positions, counted in shift-clock rising edges
`define XFER_CLOCKS           8
`define ACQ_START_RISE        5
`define MODE_RISE             6
`define RESULT_BITS           16
`define RESULT_FIRST_RISE     10
`define FRAME_CLOCKS          24
`define TAIL_END_CLOCKS       32

// ==========================================================================
// Timing: fastest shift clock and the reference clock period
`define SHIFT_CLK_MIN_PERIOD_PS 416667
`define REF_CLK_PERIOD_PS       5000
// Least half period rounds up to whole reference cycles
`define SHIFT_HALF_CYCLES \
  ((`SHIFT_CLK_MIN_PERIOD_PS + 2 * `REF_CLK_PERIOD_PS - 1) / (2 * `REF_CLK_PERIOD_PS))

// ==========================================================================
// Reset values
`define DIV_RESET             8'h00
`define CODE_RESET            16'h0000

`endif

// [src/adc_link_pkg.sv]
`default_nettype none
`include "adc_link_map.svh"

package adc_link_pkg;

  // ========================================================================
  // Device sequencer states, Gray along idle -> control -> convert
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_CTRL = 2'b01,
    D_CONV = 2'b11
  } dev_state_t;

  typedef enum logic {
    H_IDLE = 1'b0,
    H_RUN  = 1'b1
  } host_state_t;

  // ========================================================================
  // State of the converter end, rising-edge side
  typedef struct packed {
    dev_state_t  st;
    logic [2:0]  bit_cnt;
    logic [7:0]  ctrl;
    logic [4:0]  conv_cnt;
    logic [15:0] code;
    logic [2:0]  chan;
    logic        single;
    logic [1:0]  pmode;
    logic        acq;
    logic        hold;
    logic [15:0] smp1;
    logic [15:0] smp2;
  } dev_regs_t;

  // Falling-edge side of the converter end
  typedef struct packed {
    logic busy;
    logic dout;
  } dev_out_t;

  // State of the controlling end
  typedef struct packed {
    host_state_t st;
    logic        sclk;
    logic [7:0]  div;
    logic [5:0]  rise;
    logic [7:0]  ctrl;
    logic        din;
    logic [14:0] res;
    logic        lsb_due;
    logic        pend;
    logic [15:0] pdata;
    logic        dout1;
    logic        dout2;
  } host_regs_t;

  // ========================================================================
  // Control byte: start, channel, constant one, input mode, power mode
  function automatic logic [7:0] make_ctrl(input logic [2:0] ch, input logic sgl, input logic [1:0] pd);
    make_ctrl = {1'b1, ch, 1'b1, sgl, pd};
  endfunction

endpackage

`default_nettype wire

// [src/adc_link_if.sv]
`default_nettype none

// ==========================================================================
// Serial link between controller and converter
interface adc_link_if;
  logic shift_clock;
  logic din;
  logic dout;
  logic busy;

  modport device (
    input  shift_clock,
    input  din,
    output dout,
    output busy
  );

  modport host (
    output shift_clock,
    output din,
    input  dout,
    input  busy
  );
endinterface

`default_nettype wire

// [src/adc_converter_end.sv]
`default_nettype none
`include "adc_link_map.svh"

module adc_converter_end (
  adc_link_if.device        LINK,
  input  wire logic         RESETN_IN,
  input  wire logic [15:0]  SAMPLE_CODE_IN,
  output logic [2:0]        CHANNEL_SELECT_OUT,
  output logic              INPUT_MODE_SINGLE_OUT,
  output logic [1:0]        POWER_MODE_OUT,
  output logic              ACQUIRE_OUT,
  output logic              HOLD_OUT
);
  import adc_link_pkg::*;

  dev_regs_t q;
  dev_regs_t d;
  dev_out_t  oq;
  dev_out_t  od;
  logic [7:0] full_byte;

  // ========================================================================
  // Sequencer on the shift clock's rising edge
  always_comb begin
    d         = q;
    full_byte = {q.ctrl[6:0], LINK.din};
    // Quasi-static code from the analog side, two flops before use
    d.smp1    = SAMPLE_CODE_IN;
    d.smp2    = q.smp1;
    case (q.st)
      D_CTRL: begin
        d.ctrl    = full_byte;
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'(`ACQ_START_RISE - 1)) begin
          d.chan = q.ctrl[2:0];
          d.acq  = 1'b1;
        end
        if (q.bit_cnt == 3'(`MODE_RISE - 1)) begin
          d.single = LINK.din;
        end
        if (q.bit_cnt == 3'(`XFER_CLOCKS - 1)) begin
          // Eighth bit: byte complete, hold the sample and convert
          d.pmode    = full_byte[`CTRL_PD_MSB:`CTRL_PD_LSB];
          d.single   = full_byte[`CTRL_MODE_BIT];
          d.acq      = 1'b0;
          d.hold     = 1'b1;
          d.code     = q.smp2;
          d.conv_cnt = 5'h00;
          d.st       = D_CONV;
        end
      end
      D_CONV: begin
        if (q.conv_cnt != 5'(`RESULT_BITS)) begin
          d.conv_cnt = q.conv_cnt + 5'h01;
        end else begin
          // LSB is out; this rise may already carry the next start bit
          d.hold = 1'b0;
          if (LINK.din) begin
            d.st      = D_CTRL;
            d.ctrl    = 8'h01;
            d.bit_cnt = 3'h1;
          end else begin
            d.st = D_IDLE;
          end
        end
      end
      default: begin
        // Low bits before the start bit are dropped
        d.acq = 1'b0;
        if (LINK.din) begin
          d.st      = D_CTRL;
          d.ctrl    = 8'h01;
          d.bit_cnt = 3'h1;
        end
      end
    endcase
  end

  // Link clock stops between frames, so nothing here waits on idle edges
  always_ff @(posedge LINK.shift_clock or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= '{st: D_IDLE, bit_cnt: 3'h0, ctrl: 8'h00, conv_cnt: 5'h00,
             code: `CODE_RESET, chan: 3'h0, single: 1'b0, pmode: 2'h0,
             acq: 1'b0, hold: 1'b0, smp1: `CODE_RESET, smp2: `CODE_RESET};
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Busy and result bits change on the falling edge
  always_comb begin
    od.busy = (q.st == D_CONV) && (q.conv_cnt == 5'h00);
    od.dout = 1'b0;
    if ((q.st == D_CONV) && (q.conv_cnt != 5'h00)) begin
      od.dout = q.code[4'(5'(`RESULT_BITS) - q.conv_cnt)];
    end
  end

  // Zeros follow the LSB when the host keeps clocking past the frame
  always_ff @(negedge LINK.shift_clock or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      oq <= '{busy: 1'b0, dout: 1'b0};
    end else begin
      oq <= od;
    end
  end

  // ========================================================================
  // Outputs; internal clock mode is not modelled, steps follow the link
  assign LINK.dout             = oq.dout;
  assign LINK.busy             = oq.busy;
  assign CHANNEL_SELECT_OUT    = q.chan;
  assign INPUT_MODE_SINGLE_OUT = q.single;
  assign POWER_MODE_OUT        = q.pmode;
  assign ACQUIRE_OUT           = q.acq;
  assign HOLD_OUT              = q.hold;

endmodule

`default_nettype wire

// [src/adc_controller_end.sv]
`default_nettype none
`include "adc_link_map.svh"

// ==========================================================================
// Result FIFO between the link sequencer and the user
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             CLK_IN,
  input  wire logic             RESETN_IN,
  input  wire logic             IN_VALID_IN,
  output logic                  IN_READY_OUT,
  input  wire logic [WIDTH-1:0] IN_DATA_IN,
  output logic                  OUT_VALID_OUT,
  input  wire logic             OUT_READY_IN,
  output logic [WIDTH-1:0]      OUT_DATA_OUT
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign IN_READY_OUT  = cnt_q != (AW+1)'(DEPTH);
  assign OUT_VALID_OUT = cnt_q != '0;
  assign OUT_DATA_OUT  = mem[rd_q];
  assign push          = IN_VALID_IN && IN_READY_OUT;
  assign pop           = OUT_VALID_OUT && OUT_READY_IN;

  // Pointers wrap explicitly so any depth works
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage holds no reset, only written words are ever read
  always_ff @(posedge CLK_IN) begin
    if (push) begin
      mem[wr_q] <= IN_DATA_IN;
    end
  end
endmodule

// ==========================================================================
// Controlling end: makes the shift clock, sends control, collects results
module adc_controller_end #(
  parameter int HALF_CYCLES = `SHIFT_HALF_CYCLES,
  parameter int FIFO_DEPTH  = 4
) (
  adc_link_if.host          LINK,
  input  wire logic         REF_CLK_IN,
  input  wire logic         RESETN_IN,
  input  wire logic         CMD_VALID_IN,
  output logic              CMD_READY_OUT,
  input  wire logic [2:0]   CMD_CHANNEL_IN,
  input  wire logic         CMD_SINGLE_IN,
  input  wire logic [1:0]   CMD_POWER_IN,
  output logic              RESULT_VALID_OUT,
  input  wire logic         RESULT_READY_IN,
  output logic [15:0]       RESULT_DATA_OUT,
  output logic              FRAME_ACTIVE_OUT
);
  import adc_link_pkg::*;

  host_regs_t q;
  host_regs_t d;
  logic       tick;
  logic       frame_end;
  logic       can_take;
  logic       accept;
  logic       fifo_ready;
  logic [5:0] r_next;
  logic [7:0] cmd_byte;

  // ========================================================================
  // Command acceptance at idle or on the fall that closes a frame
  assign tick      = q.div == 8'(HALF_CYCLES - 1);
  assign frame_end = (q.rise == 6'(`FRAME_CLOCKS)) || (q.rise == 6'(`TAIL_END_CLOCKS));
  assign can_take  = !q.pend && ((q.st == H_IDLE) || (tick && q.sclk && frame_end));
  assign accept    = CMD_VALID_IN && can_take;
  assign cmd_byte  = make_ctrl(CMD_CHANNEL_IN, CMD_SINGLE_IN, CMD_POWER_IN);
  assign r_next    = q.rise + 6'h01;

  // A frame is 24 rises: rises 1..8 carry the control byte, the converter
  // then sits busy for one period, result bits follow on falls 9..24 and
  // the LSB is caught at rise 25. That rise is either rise 1 of the next
  // frame, when a command is ready at the fall after rise 24, or the first
  // rise of a tail byte of zeros that ends at rise 32.
  // A result still waiting for the FIFO stalls the clock low before the
  // rise that would catch the next LSB: no result is lost, but the low
  // phase stretches and the converter's held sample ages meanwhile.
  always_comb begin
    d       = q;
    d.dout1 = LINK.dout;
    d.dout2 = q.dout1;
    if (q.pend && fifo_ready) begin
      d.pend = 1'b0;
    end
    if (accept) begin
      // Start bit goes out before the first rise of the frame
      d.st   = H_RUN;
      d.ctrl = cmd_byte;
      d.din  = cmd_byte[7];
      d.rise = 6'h00;
      d.sclk = 1'b0;
      d.div  = `DIV_RESET;
    end else if (q.st == H_RUN) begin
      if (!tick) begin
        d.div = q.div + 8'h01;
      end else if (!q.sclk) begin
        // Stall the rise that would capture an LSB the FIFO cannot take
        if (!(q.lsb_due && q.pend)) begin
          d.sclk = 1'b1;
          d.div  = `DIV_RESET;
          d.rise = r_next;
          if ((r_next >= 6'(`RESULT_FIRST_RISE)) && (r_next <= 6'(`FRAME_CLOCKS))) begin
            d.res = {q.res[13:0], q.dout2};
          end
          if (q.lsb_due) begin
            d.pdata   = {q.res, q.dout2};
            d.pend    = 1'b1;
            d.lsb_due = 1'b0;
          end
          if (r_next == 6'(`FRAME_CLOCKS)) begin
            d.lsb_due = 1'b1;
          end
        end
      end else begin
        d.sclk = 1'b0;
        d.div  = `DIV_RESET;
        if (q.rise == 6'(`TAIL_END_CLOCKS)) begin
          d.st  = H_IDLE;
          d.din = 1'b0;
        end else if (q.rise < 6'(`XFER_CLOCKS)) begin
          d.din  = q.ctrl[6];
          d.ctrl = {q.ctrl[6:0], 1'b0};
        end else begin
          // Eight-clock tail byte of zeros fetches a lone LSB
          d.din = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= '{st: H_IDLE, sclk: 1'b0, div: `DIV_RESET, rise: 6'h00, ctrl: 8'h00,
             din: 1'b0, res: 15'h0000, lsb_due: 1'b0, pend: 1'b0,
             pdata: `CODE_RESET, dout1: 1'b0, dout2: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Results to the user; full FIFO stalls the link clock
  result_fifo #(
    .WIDTH (`RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .CLK_IN        (REF_CLK_IN),
    .RESETN_IN     (RESETN_IN),
    .IN_VALID_IN   (q.pend),
    .IN_READY_OUT  (fifo_ready),
    .IN_DATA_IN    (q.pdata),
    .OUT_VALID_OUT (RESULT_VALID_OUT),
    .OUT_READY_IN  (RESULT_READY_IN),
    .OUT_DATA_OUT  (RESULT_DATA_OUT)
  );

  assign CMD_READY_OUT    = can_take;
  assign FRAME_ACTIVE_OUT = q.st == H_RUN;
  assign LINK.shift_clock = q.sclk;
  assign LINK.din         = q.din;

endmodule

`default_nettype wire

// [sim/adc_link_sva.sv]
`default_nettype none

// ==========================================================================
// Link checker: watches the wire between controller and converter
module adc_link_sva #(
  parameter int HALF_CYCLES = 42
) (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic shift_clock,
  input wire logic din,
  input wire logic dout,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] pos_q;
  logic [4:0] pos_d;
  logic       sclk_q;
  logic [2:0] rise_q;
  logic [7:0] high_q;
  logic [9:0] still_q;

  // Rise number inside a frame, 0 when idle; rise 25 may open the next frame
  always_comb begin
    pos_d = pos_q + 5'h01;
    if (pos_q == 5'h00 || pos_q == 5'h18) begin
      pos_d = {4'h0, din};
    end
  end

  always_ff @(posedge shift_clock or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pos_q <= 5'h00;
    end else begin
      pos_q <= pos_d;
    end
  end

  // Rises mod 8, high time and quiet time in reference cycles
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sclk_q  <= 1'b0;
      rise_q  <= 3'h0;
      high_q  <= 8'h00;
      still_q <= 10'h000;
    end else begin
      sclk_q  <= shift_clock;
      rise_q  <= rise_q + {2'h0, shift_clock & ~sclk_q};
      high_q  <= shift_clock ? high_q + 8'h01 : 8'h00;
      still_q <= (shift_clock != sclk_q) ? 10'h000 : still_q + {9'h000, still_q != 10'h3FF}; // Saturates
    end
  end

  // ========================================================================
  // Link domain
  property p_busy_slot;
    @(posedge shift_clock) disable iff (!RESETN_IN) busy == (pos_q == 5'h08);
  endproperty
  a_busy_slot: assert property (p_busy_slot) else $error("busy outside its single period");

  property p_dout_quiet;
    @(posedge shift_clock) disable iff (!RESETN_IN) (pos_q <= 5'h08) |-> !dout;
  endproperty
  a_dout_quiet: assert property (p_dout_quiet) else $error("dout high before result bits");

  property p_const_one;
    @(posedge shift_clock) disable iff (!RESETN_IN) (pos_q == 5'h04) |-> din;
  endproperty
  a_const_one: assert property (p_const_one) else $error("fifth control bit not one");

  property p_tail;
    @(posedge shift_clock) disable iff (!RESETN_IN) (pos_q == 5'h18 && !din) |=> !din [*7];
  endproperty
  a_tail: assert property (p_tail) else $error("tail byte not all zero");

  // ========================================================================
  // Reference domain
  property p_dout_on_fall;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN) $changed(dout) |-> $fell(shift_clock);
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall) else $error("dout moved off a falling edge");

  property p_busy_on_fall;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN) $changed(busy) |-> !shift_clock && $past(shift_clock);
  endproperty
  a_busy_on_fall: assert property (p_busy_on_fall) else $error("busy moved off a falling edge");

  property p_din_on_low;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN) $changed(din) |-> !shift_clock;
  endproperty
  a_din_on_low: assert property (p_din_on_low) else $error("din moved while clock high");

  property p_half_high;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN) $fell(shift_clock) |-> int'(high_q) == HALF_CYCLES;
  endproperty
  a_half_high: assert property (p_half_high) else $error("shift clock high time wrong");

  property p_byte_groups;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN) (int'(still_q) > 2 * HALF_CYCLES) |-> rise_q == 3'h0;
  endproperty
  a_byte_groups: assert property (p_byte_groups) else $error("clock paused inside a byte");

  // Main scenarios
  c_back_to_back: cover property (@(posedge shift_clock) pos_q == 5'h18 && din);
  c_tail_byte: cover property (@(posedge shift_clock) pos_q == 5'h18 && !din);
  c_long_pause: cover property (@(posedge REF_CLK_IN) still_q == 10'h3FF);
endmodule

`default_nettype wire

// [sim/sar_adc_serial_control_frame_tb.sv]
`default_nettype none

// ==========================================================================
// Controller and converter face each other; a second converter is hand driven
module sar_adc_serial_control_frame_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 16; // 160 ns link period
  localparam logic [7:0] CTL2 = 8'hEB; // Channel 6, differential, power code 3
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_single = 1'b0;
  logic        res_ready = 1'b0;
  logic        stall = 1'b0;
  logic [2:0]  cmd_ch = 3'h0;
  logic [1:0]  cmd_pd = 2'h0;
  logic [15:0] code = 16'h0000;
  logic [15:0] code2 = 16'h0000;
  logic        cmd_ready, res_valid, frame_act, acq, hold, single, acq2, hold2, single2;
  logic [15:0] res_data;
  logic [2:0]  chan, chan2;
  logic [1:0]  pwr, pwr2;
  int          err_total = 0;
  int          total_checks = 0;
  int          seed = 40;
  int          sum_got = 0;
  int          sum_exp = 0;
  int          n_got = 0;
  logic [15:0] exp_w;
  logic [15:0] exp_q[$];

  adc_link_if link_bus ();
  adc_link_if link_bad ();

  always #2.5 clk = ~clk;

  adc_controller_end #(.HALF_CYCLES(HALF), .FIFO_DEPTH(4)) u_adc_controller_end (.LINK(link_bus),
    .REF_CLK_IN(clk), .RESETN_IN(rst_n), .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .CMD_CHANNEL_IN(cmd_ch), .CMD_SINGLE_IN(cmd_single), .CMD_POWER_IN(cmd_pd), .RESULT_VALID_OUT(res_valid),
    .RESULT_READY_IN(res_ready), .RESULT_DATA_OUT(res_data), .FRAME_ACTIVE_OUT(frame_act));
  adc_converter_end u_adc_converter_end (.LINK(link_bus), .RESETN_IN(rst_n), .SAMPLE_CODE_IN(code),
    .CHANNEL_SELECT_OUT(chan), .INPUT_MODE_SINGLE_OUT(single), .POWER_MODE_OUT(pwr), .ACQUIRE_OUT(acq),
    .HOLD_OUT(hold));
  adc_converter_end u_adc_converter_end_2 (.LINK(link_bad), .RESETN_IN(rst_n), .SAMPLE_CODE_IN(code2),
    .CHANNEL_SELECT_OUT(chan2), .INPUT_MODE_SINGLE_OUT(single2), .POWER_MODE_OUT(pwr2), .ACQUIRE_OUT(acq2),
    .HOLD_OUT(hold2));
  adc_link_sva #(.HALF_CYCLES(HALF)) u_adc_link_sva (.REF_CLK_IN(clk), .RESETN_IN(rst_n),
    .shift_clock(link_bus.shift_clock), .din(link_bus.din), .dout(link_bus.dout), .busy(link_bus.busy));

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctl(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: control got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Offer one command, note its code, then watch sampling and hold begin
  task automatic send(input logic [2:0] ch, input logic sgl, input logic [1:0] pd, input logic [15:0] c);
    int n;
    @(posedge clk);
    #1 code = c;
    cmd_ch = ch;
    cmd_single = sgl;
    cmd_pd = pd;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 9000);
    cmp_word(16'(n >= 9000), 16'h0000);
    exp_q.push_back(c);
    sum_exp += c;
    #1 cmd_valid = 1'b0;
    n = 0;
    while (acq !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    cmp_word({12'h000, chan, hold}, {12'h000, ch, 1'b0});
    while (hold !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    cmp_ctl({chan, single, pwr}, {ch, sgl, pd});
    cmp_word(16'(n >= 9000), 16'h0000);
  endtask

  // Wait until every noted result is out and the link is idle
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || frame_act !== 1'b0) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    cmp_word(16'(n >= 20000), 16'h0000);
  endtask

  // One hand-made link period; din moves only while the clock is low
  task automatic pulse2(input logic b);
    link_bad.din = b;
    #79 link_bad.shift_clock = 1'b1;
    #80 link_bad.shift_clock = 1'b0;
  endtask

  // Random back-pressure, or a full stop while stalled
  always @(posedge clk) begin
    #1 res_ready = !stall && ($random(seed) & 1) != 0;
  end

  // Scoreboard: each word leaving the FIFO against the oldest note
  always @(posedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      sum_got += res_data;
      n_got++;
      // A word with no note behind it can never match, even when unknown
      exp_w = (res_data === 16'h0000) ? 16'hFFFF : 16'h0000;
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
      end
      cmp_word(res_data, exp_w);
    end
  end

  initial begin
    #300000;
    err_total++;
    conclude();
  end

  initial begin
    link_bad.shift_clock = 1'b0;
    link_bad.din = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    // Every channel code, both input modes and all power codes, back to back
    for (int i = 0; i < 8; i++) send(i[2:0], i[0], i[1:0], 16'($random(seed)));
    drain();
    // Results left waiting: four fill the FIFO, a fifth waits, the sixth LSB stalls the link
    stall = 1'b1;
    for (int i = 0; i < 6; i++) send(3'h7 - i[2:0], i[1], 2'h3, 16'($random(seed)));
    repeat (2000) @(posedge clk);
    #1 cmp_word({13'h0000, link_bus.shift_clock, frame_act, res_valid}, 16'h0003);
    #1 stall = 1'b0;
    drain();
    cmp_word(16'(exp_q.size()), 16'h0000);
    // Mean of all 14 results, as a host filtering noisy codes would take it
    cmp_word(16'(sum_got / (n_got > 0 ? n_got : 1)), 16'(sum_exp / 14));
    // Stray low bits ahead of the start bit, then a differential frame
    code2 = 16'($random(seed));
    #3.3;
    for (int i = -2; i <= 32; i++) begin
      pulse2((i >= 1 && i <= 8) ? CTL2[8 - i] : 1'b0);
      #1 cmp_word({12'h000, acq2, hold2, link_bad.busy, link_bad.dout}, {12'h000, i >= 5 && i <= 7,
        i >= 8 && i <= 24, i == 8, (i >= 9 && i <= 24) ? code2[24 - i] : 1'b0});
      if (i == 5 || i == 8) cmp_ctl({chan2, single2, pwr2}, {3'h6, 1'b0, i == 8 ? 2'h3 : 2'h0});
    end
    conclude();
  end
endmodule

`default_nettype wire
